// ---- rtl/tirc_consts.vh ----
// constants for the timer, interrupt and reset control block
`ifndef TIRC_CONSTS_VH
`define TIRC_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define TIRC_CLK_HZ          50000000
`define TIRC_TICK_FAST_NS    5000
`define TIRC_TICK_SLOW_NS    82000
`define TIRC_TICK_FAST_CYC   ((`TIRC_TICK_FAST_NS * (`TIRC_CLK_HZ / 1000000)) / 1000)
`define TIRC_TICK_SLOW_CYC   ((`TIRC_TICK_SLOW_NS * (`TIRC_CLK_HZ / 1000000)) / 1000)
`define TIRC_RST_MIN_NS      4000
`define TIRC_RST_MIN_CYC     (((`TIRC_RST_MIN_NS * (`TIRC_CLK_HZ / 1000000)) + 999) / 1000 + 1)

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TIRC_COUNT_RST       8'hFF
`define TIRC_DIR_RST         8'hFF
`define TIRC_PC_RST          16'h0000
`define TIRC_FLAGS_RST       8'h00

// ----------------------------------------------------------------
// interrupt vectors
// ----------------------------------------------------------------
`define TIRC_VEC_LEVEL       16'h0004
`define TIRC_VEC_TIMER       16'h0008
`define TIRC_VEC_EDGE        16'h0010

// ----------------------------------------------------------------
// source bit positions
// ----------------------------------------------------------------
`define TIRC_SRC_LEVEL       0
`define TIRC_SRC_TIMER       1
`define TIRC_SRC_EDGE        2

`endif

// ---- rtl/tirc_sync.v ----
// two flip-flop synchroniser for one external level
module tirc_sync (
    ref_clk,
    resetn,
    async_in,
    sync_out
);
    input  wire ref_clk;   // block clock
    input  wire resetn;    // synchronous reset, active low
    input  wire async_in;  // pin level from outside
    output reg  sync_out;  // level after two stages

    reg meta_reg;          // first stage, read only by second

    // ------------------------------------------------------------
    // two stage capture
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // tirc_sync

// ---- rtl/tirc_ctrl.v ----
// timer, vectored interrupt and reset sequencing control block
// Notes on behaviour
// - 8-bit counter ticked at 5us or 82us
// - counter idle until start instruction executes
// - count matching compare register raises timer request
// - compare register rewritable, new value used later
// - start sets timer flop, match clears it
// - three sources: two external, one timer
// - vectors 4, 8, 16 by priority
// - masked sources never cause a branch
// - reset low over 4us enters reset
// - reset clears enables and pending requests
// - reset clears halt flop, releases halt
// - reset sets port B direction all ones
// - reset clears every processor flag
// - reset presets count FFH, clears flop
// - reset clears program counter to zero
// - reset floats data bus and strobes

// shared offsets, reset values and timing counts, needed by the parameter defaults
`include "tirc_consts.vh"

module tirc_ctrl #(
    parameter RST_MIN_CYC = `TIRC_RST_MIN_CYC,   // reset filter length in cycles
    parameter TICK_FAST   = `TIRC_TICK_FAST_CYC, // fast prescaler period
    parameter TICK_SLOW   = `TIRC_TICK_SLOW_CYC  // slow prescaler period
) (
    ref_clk,
    resetn,
    reset_pin_n,
    start_timer_instruction,
    tick_slow_sel,
    compare_wr,
    compare_data,
    ext_level_irq,
    ext_edge_irq,
    int_enable_set,
    int_mask,
    irq_ack,
    halt_req,
    dir_wr,
    dir_data,
    flags_wr,
    flags_data,
    pc_load,
    pc_data,
    bus_drive_req,
    timer_flop_output,
    timer_count,
    irq_request,
    irq_vector,
    irq_pending,
    int_enable,
    halt_state,
    port_b_direction,
    cpu_flags,
    prog_counter,
    in_reset,
    ext_data_bus_oe,
    strobe_oe
);

    input  wire        ref_clk;                 // 50 MHz block clock
    input  wire        resetn;                  // synchronous system reset, active low
    input  wire        reset_pin_n;             // external reset pin, active low
    input  wire        start_timer_instruction; // one-cycle pulse from core
    input  wire        tick_slow_sel;           // 0: fast tick, 1: slow tick
    input  wire        compare_wr;              // write strobe for compare register
    input  wire [7:0]  compare_data;            // new compare value
    input  wire        ext_level_irq;           // level request pin, active high
    input  wire        ext_edge_irq;            // rising edge request pin
    input  wire        int_enable_set;          // core sets global enable
    input  wire [2:0]  int_mask;                // 1 masks that source
    input  wire        irq_ack;                 // core takes the offered vector
    input  wire        halt_req;                // core enters halt
    input  wire        dir_wr;                  // write port B direction
    input  wire [7:0]  dir_data;                // direction data
    input  wire        flags_wr;                // write processor flags
    input  wire [7:0]  flags_data;              // flag data
    input  wire        pc_load;                 // program counter load strobe
    input  wire [15:0] pc_data;                 // program counter value
    input  wire        bus_drive_req;           // core wants the bus driven
    output reg         timer_flop_output;       // timer flop to pin
    output reg  [7:0]  timer_count;             // current up-count
    output reg         irq_request;             // branch offered to core
    output reg  [15:0] irq_vector;              // vector of offered branch
    output reg  [2:0]  irq_pending;             // latched requests
    output reg         int_enable;              // global interrupt enable
    output reg         halt_state;              // halt flop
    output reg  [7:0]  port_b_direction;        // 1 = input
    output reg  [7:0]  cpu_flags;               // processor flags
    output reg  [15:0] prog_counter;            // program counter
    output reg         in_reset;                // reset condition active
    output reg         ext_data_bus_oe;         // data bus drive enable
    output reg         strobe_oe;               // read/write strobe drive enable

    // ------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------
    wire        rst_pin_s;       // synchronised reset pin, high = low pin
    wire        lvl_s;           // synchronised level request
    wire        edg_s;           // synchronised edge request
    reg         edg_d_reg;       // previous edge input
    reg  [15:0] rst_cnt_reg;     // low-time counter on the reset pin
    reg  [15:0] pre_cnt_reg;     // prescaler counter
    reg         running_reg;     // timer started
    reg  [7:0]  compare_reg;     // timer compare value
    wire        tick;            // prescaler tick
    wire [7:0]  count_inc;       // next count
    wire        match;           // count hits compare
    wire        sys_rst;         // combined reset
    wire [2:0]  live;            // requests gated by mask and enable
    wire [15:0] tick_len;        // chosen prescaler period

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // reset pin synchronised
    tirc_sync u_sync_rst (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (~reset_pin_n),
        .sync_out (rst_pin_s)
    );
    tirc_sync u_sync_lvl (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (ext_level_irq),
        .sync_out (lvl_s)
    );
    tirc_sync u_sync_edg (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (ext_edge_irq),
        .sync_out (edg_s)
    );

    // ------------------------------------------------------------
    // reset pin filter
    // ------------------------------------------------------------
    // pin must stay low the full minimum time
    // a pin glitch shorter than the filter restarts the count
    always @(posedge ref_clk) begin
        if (!resetn) begin
            rst_cnt_reg <= 16'h0000;
            in_reset    <= 1'b0;
        end else if (!rst_pin_s) begin
            rst_cnt_reg <= 16'h0000;
            in_reset    <= 1'b0;
        end else if (rst_cnt_reg < RST_MIN_CYC[15:0]) begin
            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
        end else begin
            in_reset    <= 1'b1;
        end
    end

    assign sys_rst  = !resetn || in_reset;

    // ------------------------------------------------------------
    // prescaler and up-counter
    // ------------------------------------------------------------
    // two fixed tick rates
    assign tick_len  = tick_slow_sel ? TICK_SLOW[15:0] : TICK_FAST[15:0];
    assign tick      = running_reg && (pre_cnt_reg >= tick_len - 16'h0001);
    assign count_inc = timer_count + 8'h01;
    assign match     = tick && (count_inc == compare_reg);

    // timer run state, prescaler, count and flop
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_count       <= `TIRC_COUNT_RST;
            timer_flop_output <= 1'b0;
            running_reg       <= 1'b0;
            pre_cnt_reg       <= 16'h0000;
        end else if (start_timer_instruction) begin
            running_reg       <= 1'b1;
            pre_cnt_reg       <= 16'h0000;
            timer_count       <= 8'h00;
            timer_flop_output <= 1'b1;
        end else if (tick) begin
            pre_cnt_reg <= 16'h0000;
            if (match) begin
                timer_count       <= 8'h00;
                timer_flop_output <= 1'b0;
            end else begin
                timer_count <= count_inc;
            end
        end else if (running_reg) begin
            pre_cnt_reg <= pre_cnt_reg + 16'h0001;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            compare_reg <= 8'hFF;
        end else if (compare_wr) begin
            compare_reg <= compare_data;
        end
    end

    // ------------------------------------------------------------
    // interrupt pending, priority and vector
    // ------------------------------------------------------------
    // mask and global enable gate each source
    assign live = irq_pending & ~int_mask & {3{int_enable}};

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_pending <= 3'b000;
            int_enable  <= 1'b0;
            irq_request <= 1'b0;
            irq_vector  <= 16'h0000;
            edg_d_reg   <= 1'b0;
        end else begin
            edg_d_reg <= edg_s;
            if (int_enable_set) begin
                int_enable <= 1'b1;
            end else if (irq_ack && irq_request) begin
                int_enable <= 1'b0;
            end
            irq_pending[`TIRC_SRC_LEVEL] <= lvl_s;
            // timer request; set wins over acknowledge
            if (match) begin
                irq_pending[`TIRC_SRC_TIMER] <= 1'b1;
            end else if (irq_ack && irq_request && irq_vector == `TIRC_VEC_TIMER) begin
                irq_pending[`TIRC_SRC_TIMER] <= 1'b0;
            end
            // rising edge latched; set wins over acknowledge
            if (edg_s && !edg_d_reg) begin
                irq_pending[`TIRC_SRC_EDGE] <= 1'b1;
            end else if (irq_ack && irq_request && irq_vector == `TIRC_VEC_EDGE) begin
                irq_pending[`TIRC_SRC_EDGE] <= 1'b0;
            end
            // lowest priority number wins, others wait
            if (irq_ack && irq_request) begin
                irq_request <= 1'b0;
            end else if (live[`TIRC_SRC_LEVEL]) begin
                irq_request <= 1'b1;
                irq_vector  <= `TIRC_VEC_LEVEL;
            end else if (live[`TIRC_SRC_TIMER]) begin
                irq_request <= 1'b1;
                irq_vector  <= `TIRC_VEC_TIMER;
            end else if (live[`TIRC_SRC_EDGE]) begin
                irq_request <= 1'b1;
                irq_vector  <= `TIRC_VEC_EDGE;
            end else begin
                irq_request <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // core state under reset
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            halt_state       <= 1'b0;
            port_b_direction <= `TIRC_DIR_RST;
            cpu_flags        <= `TIRC_FLAGS_RST;
            prog_counter     <= `TIRC_PC_RST;
            ext_data_bus_oe  <= 1'b0;
            strobe_oe        <= 1'b0;
        end else begin
            if (halt_req) begin
                halt_state <= 1'b1;
            end else if (irq_request) begin
                halt_state <= 1'b0;
            end
            if (dir_wr) begin
                port_b_direction <= dir_data;
            end
            if (flags_wr) begin
                cpu_flags <= flags_data;
            end
            if (pc_load) begin
                prog_counter <= pc_data;
            end
            ext_data_bus_oe <= bus_drive_req;
            strobe_oe       <= 1'b1;
        end
    end
endmodule // tirc_ctrl

// ---- dv/tirc_checker.sv ----
// concurrent checks on the ports of the timer, interrupt and reset block
module tirc_checker (
    input wire        ref_clk,
    input wire        resetn,
    input wire        start_timer_instruction,
    input wire        int_enable_set,
    input wire [2:0]  int_mask,
    input wire        irq_ack,
    input wire        timer_flop_output,
    input wire [7:0]  timer_count,
    input wire        irq_request,
    input wire [15:0] irq_vector,
    input wire [2:0]  irq_pending,
    input wire        int_enable,
    input wire        halt_state,
    input wire [7:0]  port_b_direction,
    input wire [7:0]  cpu_flags,
    input wire [15:0] prog_counter,
    input wire        in_reset,
    input wire        ext_data_bus_oe,
    input wire        strobe_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    // vector of the lowest-numbered open source
    function automatic [15:0] vec_of(input [2:0] p);
        vec_of = p[0] ? 16'h0004 : p[1] ? 16'h0008 : p[2] ? 16'h0010 : 16'h0000;
    endfunction
    a_reset_state: assert property (!resetn |=> port_b_direction == 8'hFF && cpu_flags == 8'h00 &&
        prog_counter == 16'h0000 && timer_count == 8'hFF && !timer_flop_output) else $error("reset state wrong");
    a_reset_irq: assert property (!resetn |=> !irq_request && irq_pending == 3'h0 && !int_enable &&
        !halt_state && !ext_data_bus_oe && !strobe_oe) else $error("reset irq or bus state wrong");
    a_pin_reset: assert property (disable iff (!resetn) $past(in_reset) && in_reset |->
        !ext_data_bus_oe && !strobe_oe && !halt_state && port_b_direction == 8'hFF) else $error("pin reset state wrong");
    a_start_flop: assert property (disable iff (!resetn) start_timer_instruction && !in_reset |=>
        timer_flop_output && timer_count == 8'h00) else $error("start did not set flop");
    a_idle_hold: assert property (disable iff (!resetn) timer_count == 8'hFF && !timer_flop_output &&
        !start_timer_instruction |=> timer_count == 8'hFF) else $error("counter moved before start");
    a_match_clear: assert property (disable iff (!resetn) $fell(timer_flop_output) && !in_reset |->
        timer_count == 8'h00 ##[0:1] irq_pending[1]) else $error("match did not clear flop or raise request");
    a_prio_vector: assert property (disable iff (!resetn || in_reset) $rose(irq_request) |->
        irq_vector == vec_of($past(irq_pending) & ~$past(int_mask))) else $error("wrong vector offered");
    a_enable_gate: assert property (disable iff (!resetn) !int_enable && !int_enable_set && !irq_request
        |=> !irq_request) else $error("request while disabled");
    a_ack_clear: assert property (disable iff (!resetn) irq_request && irq_ack && !int_enable_set |=>
        !irq_request && !int_enable) else $error("ack did not withdraw request");
    c_request: cover property (disable iff (!resetn) $rose(irq_request));
    c_match: cover property (disable iff (!resetn) $fell(timer_flop_output));
    c_pin_reset: cover property (disable iff (!resetn) $rose(in_reset));
endmodule // tirc_checker

bind tirc_ctrl tirc_checker tirc_checker_inst (.ref_clk, .resetn, .start_timer_instruction, .int_enable_set,
    .int_mask, .irq_ack, .timer_flop_output, .timer_count, .irq_request, .irq_vector, .irq_pending, .int_enable,
    .halt_state, .port_b_direction, .cpu_flags, .prog_counter, .in_reset, .ext_data_bus_oe, .strobe_oe);

// ---- dv/tirc_ext_src.sv ----
// model of the external request pins and the reset pin source
module tirc_ext_src (
    input  wire  ref_clk,
    output logic level_irq,
    output logic edge_irq,
    output logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        level_irq   = 1'b0;
        edge_irq    = 1'b0;
        reset_pin_n = 1'b1;
    end
    // level source: held until the handler is done
    task automatic set_level(input logic v);
        @(negedge ref_clk) level_irq = v;
    endtask
    // edge source: one rising edge, held long enough to synchronise
    task automatic edge_pulse();
        @(negedge ref_clk) edge_irq = 1'b1;
        repeat (4) @(negedge ref_clk);
        edge_irq = 1'b0;
    endtask
    // pin held low until the caller releases it past the minimum
    task automatic pin(input logic v);
        @(negedge ref_clk) reset_pin_n = v;
    endtask
endmodule // tirc_ext_src

// ---- dv/test_tirc_ctrl.sv ----
// self-checking bench for the timer, interrupt and reset block
module test_tirc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam TF = 3, TS = 5, RM = 4; // shortened tick and reset filter counts
    logic ref_clk = 1'b0, resetn = 1'b0, st = 1'b0, slow = 1'b0, cwr = 1'b0, ens = 1'b0, ack = 1'b0;
    logic halt = 1'b0, dwr = 1'b0, fwr = 1'b0, pcl = 1'b0, drv = 1'b0;
    logic [7:0] cdat = 8'h00, ddat = 8'h00, fdat = 8'h00;
    logic [15:0] pdat = 16'h0000;
    logic [2:0] mask = 3'h7;
    wire lvl, edg, pin_n, flop, req, en, hst, inr, doe, soe;
    wire [7:0] cnt, dir, flg;
    wire [15:0] vec, pc;
    wire [2:0] pend;
    int failures = 0, comparisons = 0, n;
    always #10 ref_clk = ~ref_clk;
    tirc_ext_src tirc_ext_src_inst (.ref_clk(ref_clk), .level_irq(lvl), .edge_irq(edg), .reset_pin_n(pin_n));
    tirc_ctrl #(.RST_MIN_CYC(RM), .TICK_FAST(TF), .TICK_SLOW(TS)) tirc_ctrl_inst (.ref_clk(ref_clk),
        .resetn(resetn), .reset_pin_n(pin_n), .start_timer_instruction(st), .tick_slow_sel(slow),
        .compare_wr(cwr), .compare_data(cdat), .ext_level_irq(lvl), .ext_edge_irq(edg), .int_enable_set(ens),
        .int_mask(mask), .irq_ack(ack), .halt_req(halt), .dir_wr(dwr), .dir_data(ddat), .flags_wr(fwr),
        .flags_data(fdat), .pc_load(pcl), .pc_data(pdat), .bus_drive_req(drv), .timer_flop_output(flop),
        .timer_count(cnt), .irq_request(req), .irq_vector(vec), .irq_pending(pend), .int_enable(en),
        .halt_state(hst), .port_b_direction(dir), .cpu_flags(flg), .prog_counter(pc), .in_reset(inr),
        .ext_data_bus_oe(doe), .strobe_oe(soe));
    // compare one value and report a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // print the counts and the verdict, then end the run
    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one-cycle strobe launched at the falling edge
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1'b1;
        @(negedge ref_clk) s = 1'b0;
    endtask
    // bounded wait: 0 request, 1 timer flop, 2 reset condition
    task automatic wait_for(input int sel, input logic v);
        n = 0;
        while (((sel == 0) ? req : (sel == 1) ? flop : inr) !== v) begin
            @(negedge ref_clk);
            n++;
            if (n > 100) begin
                chk(16'h0BAD, 16'h0000);
                stop_test();
            end
        end
    endtask
    // timer run: program compare, start, time the match
    task automatic run_timer(input logic [7:0] c, input int t);
        cdat = c;
        pulse(cwr);
        pulse(st);
        chk({flop, cnt}, 16'h0100);
        wait_for(1, 1'b0);
        chk(n >= (c - 1) * t && n <= c * t + 2, 1'b1);
    endtask
    // serve one offered interrupt and check its withdrawal
    task automatic serve(input logic [15:0] v);
        pulse(ens);
        wait_for(0, 1'b1);
        chk(vec, v);
        pulse(ack);
        @(negedge ref_clk);
        chk({req, en}, 16'h0000);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        chk({dir, flg, cnt, 5'h00, flop, doe, soe}, 32'hFF00FF00);
        chk({pc, pend, en, hst}, 16'h0000);
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        chk(soe, 1'b1);
        ddat = 8'h0F;
        fdat = 8'hA5;
        pdat = 16'h1234;
        pulse(dwr);
        pulse(fwr);
        pulse(pcl);
        chk({dir, flg}, 16'h0FA5);
        chk(pc, 16'h1234);
        repeat (10) @(negedge ref_clk);
        chk(cnt, 8'hFF);
        run_timer(8'h03, TF);
        @(negedge ref_clk);
        chk(pend, 3'b010);
        slow = 1'b1;
        run_timer(8'h02, TS);
        tirc_ext_src_inst.set_level(1'b1);
        tirc_ext_src_inst.edge_pulse();
        pulse(ens);
        repeat (8) @(negedge ref_clk);
        chk({req, pend}, 4'h7);
        mask = 3'h0;
        serve(16'h0004);
        tirc_ext_src_inst.set_level(1'b0);
        repeat (4) @(negedge ref_clk);
        serve(16'h0008);
        serve(16'h0010);
        chk(pend, 3'h0);
        pulse(halt);
        drv = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({hst, doe}, 2'b11);
        tirc_ext_src_inst.pin(1'b0);
        wait_for(2, 1'b1);
        chk(n >= RM && n <= RM + 4, 1'b1);
        @(negedge ref_clk);
        chk({hst, doe, soe, dir}, 11'h0FF);
        chk({pc, cnt}, 24'h0000FF);
        tirc_ext_src_inst.pin(1'b1);
        wait_for(2, 1'b0);
        chk(n <= 3, 1'b1);
        stop_test();
    end
endmodule // test_tirc_ctrl
